// ===== pkg/perf_event_pkg.sv
// package for the performance event counter block
// assumes a single processor clock and coprocessor-0 style move ports
package perf_event_pkg;

    localparam logic [4:0] PERF_REG_SELECTOR = 5'h19;
    localparam logic [1:0] SEL_CONTROL_0     = 2'h0;
    localparam logic [1:0] SEL_COUNTER_0     = 2'h1;
    localparam logic [1:0] SEL_CONTROL_1     = 2'h2;
    localparam logic [1:0] SEL_COUNTER_1     = 2'h3;

    // control register fields
    localparam int CTL_EVENT_LSB  = 5;
    localparam int CTL_EVENT_MSB  = 8;
    localparam int CTL_IRQ_EN_BIT = 4;
    localparam int CTL_EN_EXC     = 3;
    localparam int CTL_EN_KERNEL  = 2;
    localparam int CTL_EN_SUPER   = 1;
    localparam int CTL_EN_USER    = 0;
    localparam logic [31:0] CTL_RESET   = 32'h0000_0000;
    localparam logic [31:0] CTL_MASK    = 32'h0000_01FF;
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam int COUNT_MSB = 31;

    // privilege mode field encodings
    localparam logic [1:0] MODE_KERNEL = 2'h0;
    localparam logic [1:0] MODE_SUPER  = 2'h1;
    localparam logic [1:0] MODE_USER   = 2'h2;

    // event source pulses, all on the processor clock
    typedef struct packed {
        logic       branch_resolved;
        logic       sc_wb_quadword;
        logic       sc_ecc_corrected;
        logic       icache_refill_req;
        logic       imiss_last_qw;
        logic       sc_way_retry_i;
        logic       ext_interv_enter;
        logic       ext_inval_enter;
        logic [3:0] unit_done;
        logic [2:0] grad_count;
        logic [2:0] fp_grad_count;
        logic       dc_wb_quadword;
        logic       xlate_handler_entry;
        logic       branch_restored;
        logic       dcache_req_enter;
        logic       dmiss_second_qw;
        logic       sc_way_retry_d;
        logic       ext_interv_hit;
        logic       ext_inval_hit;
        logic       ce_to_dirty_req;
        logic       sh_to_dirty_req;
    } perf_events_s;

    // processor status bits that qualify counting
    typedef struct packed {
        logic [1:0] privilege_mode_field;
        logic       exception_level;
        logic       error_level;
    } perf_status_s;

endpackage : perf_event_pkg

// ===== rtl/perf_event_counters.sv
// two performance event counters with their control registers
// assumes event pulses and status bits are synchronous to I_REF_CLK
`timescale 1ns/10ps

// Behaviour
// - counter 1 event 5 adds floating-point instructions graduated, 0 to 4
// - counter 0 event 6 adds one per cycle with branches resolved
// - counter 1 event 6 counts quadwords written back from data cache
// - counter 0 event 7 counts secondary quadwords into outgoing buffer
// - counter 1 event 7 counts every translation miss handler entry
// - counter 0 event 8 counts corrected single-bit secondary errors
// - counter 1 event 8 counts mispredicted branch restores
// - counter 0 event 9 counts instruction refill requests queued
// - counter 1 event 9 counts data cache requests entering queue
// - event 10 counts instruction and data secondary misses
// - event 11 counts secondary way mispredict retries, per cache
// - counter 0 events 12, 13 count external requests entering queue
// - counter 1 events 12, 13 count external requests hitting secondary
// - counter 0 event 14 adds one when any unit marks done
// - counter 1 events 14, 15 count dirty-exclusive upgrade requests
// - counter 0 event 15 adds instructions graduated
// - selector 11001 moves reach controls and counters by low bits
// - control holds event select, interrupt enable, four mode enables
// - mode enables qualify counting by privilege and exception level
// - error level set stops all counting
// - undefined control bits are reserved
// - interrupt line seven driven only with enable set
// - overflow with enable asserts interrupt line seven
// - reserved control bits read as zero
// - event 0 counts every clock cycle
module perf_event_counters
    import perf_event_pkg::*;
(
    input  wire logic         I_REF_CLK,
    input  wire logic         I_RSTN,
    input  wire logic         I_MOVE_TO_COPROCESSOR_ZERO,
    input  wire logic         I_MOVE_FROM_COPROCESSOR_ZERO,
    input  wire logic [4:0]   I_REG_SELECTOR,
    input  wire logic [1:0]   I_OPCODE_LOW,
    input  wire logic [31:0]  I_WRITE_DATA,
    input  perf_events_s      I_EVENTS,
    input  perf_status_s      I_STATUS,
    output logic [31:0]       O_READ_DATA,
    output logic              O_READ_VALID,
    output logic              O_SHARED_INTERRUPT_LINE_SEVEN
);

    //--------------------------------------------------------------
    // register access decode
    //--------------------------------------------------------------
    logic [31:0] control [2];
    logic [31:0] count   [2];
    logic        wr_hit;
    logic        rd_hit;
    logic        mode_ok [2];
    logic [2:0]  inc     [2];

    // only the performance selector reaches these registers
    assign wr_hit = I_MOVE_TO_COPROCESSOR_ZERO
        && (I_REG_SELECTOR == PERF_REG_SELECTOR);
    assign rd_hit = I_MOVE_FROM_COPROCESSOR_ZERO
        && (I_REG_SELECTOR == PERF_REG_SELECTOR);

    //--------------------------------------------------------------
    // event selection per counter
    //--------------------------------------------------------------
    // counter 0 increment from the selected event
    always_comb begin
        inc[0] = 3'h0;
        unique case (control[0][CTL_EVENT_MSB:CTL_EVENT_LSB])
            4'h0: inc[0] = 3'h1;
            4'h6: inc[0] = {2'h0, I_EVENTS.branch_resolved};
            4'h7: inc[0] = {2'h0, I_EVENTS.sc_wb_quadword};
            4'h8: inc[0] = {2'h0, I_EVENTS.sc_ecc_corrected};
            4'h9: inc[0] = {2'h0, I_EVENTS.icache_refill_req};
            4'hA: inc[0] = {2'h0, I_EVENTS.imiss_last_qw};
            4'hB: inc[0] = {2'h0, I_EVENTS.sc_way_retry_i};
            4'hC: inc[0] = {2'h0, I_EVENTS.ext_interv_enter};
            4'hD: inc[0] = {2'h0, I_EVENTS.ext_inval_enter};
            4'hE: inc[0] = {2'h0, |I_EVENTS.unit_done};
            4'hF: inc[0] = I_EVENTS.grad_count;
            default: inc[0] = 3'h0;
        endcase
    end

    // counter 1 increment from the selected event
    always_comb begin
        inc[1] = 3'h0;
        unique case (control[1][CTL_EVENT_MSB:CTL_EVENT_LSB])
            4'h0: inc[1] = 3'h1;
            4'h5: inc[1] = I_EVENTS.fp_grad_count;
            4'h6: inc[1] = {2'h0, I_EVENTS.dc_wb_quadword};
            4'h7: inc[1] = {2'h0, I_EVENTS.xlate_handler_entry};
            4'h8: inc[1] = {2'h0, I_EVENTS.branch_restored};
            4'h9: inc[1] = {2'h0, I_EVENTS.dcache_req_enter};
            4'hA: inc[1] = {2'h0, I_EVENTS.dmiss_second_qw};
            4'hB: inc[1] = {2'h0, I_EVENTS.sc_way_retry_d};
            4'hC: inc[1] = {2'h0, I_EVENTS.ext_interv_hit};
            4'hD: inc[1] = {2'h0, I_EVENTS.ext_inval_hit};
            4'hE: inc[1] = {2'h0, I_EVENTS.ce_to_dirty_req};
            4'hF: inc[1] = {2'h0, I_EVENTS.sh_to_dirty_req};
            default: inc[1] = 3'h0;
        endcase
    end

    //--------------------------------------------------------------
    // per-counter mode qualification, control and count storage
    //--------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_chan
            localparam logic [1:0] CTL_SEL = g ? SEL_CONTROL_1 : SEL_CONTROL_0;
            localparam logic [1:0] CNT_SEL = g ? SEL_COUNTER_1 : SEL_COUNTER_0;
            logic user_ok;
            logic super_ok;
            logic kern_ok;
            logic exc_ok;

            // mode enables, any combination, error level blocks all
            assign user_ok  = control[g][CTL_EN_USER]
                && I_STATUS.privilege_mode_field == MODE_USER
                && !I_STATUS.exception_level;
            assign super_ok = control[g][CTL_EN_SUPER]
                && I_STATUS.privilege_mode_field == MODE_SUPER
                && !I_STATUS.exception_level;
            assign kern_ok  = control[g][CTL_EN_KERNEL]
                && I_STATUS.privilege_mode_field == MODE_KERNEL
                && !I_STATUS.exception_level;
            assign exc_ok   = control[g][CTL_EN_EXC]
                && I_STATUS.exception_level;
            assign mode_ok[g] = !I_STATUS.error_level
                && (user_ok || super_ok || kern_ok || exc_ok);

            // control register, reserved bits kept at zero
            always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
                if (!I_RSTN) begin
                    control[g] <= CTL_RESET;
                end else if (wr_hit && I_OPCODE_LOW == CTL_SEL) begin
                    control[g] <= I_WRITE_DATA & CTL_MASK;
                end
            end

            // counter: software preload wins, else add whole increment
            always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
                if (!I_RSTN) begin
                    count[g] <= COUNT_RESET;
                end else if (wr_hit && I_OPCODE_LOW == CNT_SEL) begin
                    count[g] <= I_WRITE_DATA;
                end else if (mode_ok[g]) begin
                    count[g] <= count[g] + {29'h0, inc[g]};
                end
            end

            // a selected event must land in the counter next cycle
            a_count_adds_event: assert property (
                @(posedge I_REF_CLK) disable iff (!I_RSTN)
                (mode_ok[g] && !(wr_hit && I_OPCODE_LOW == CNT_SEL))
                |=> count[g] == $past(count[g]) + {29'h0, $past(inc[g])})
                else $error("counter did not add its selected event");

            a_error_blocks: assert property (
                @(posedge I_REF_CLK) disable iff (!I_RSTN)
                (I_STATUS.error_level
                 && !(wr_hit && I_OPCODE_LOW == CNT_SEL))
                |=> $stable(count[g]))
                else $error("counter moved while error level set");

            a_reserved_zero: assert property (
                @(posedge I_REF_CLK) disable iff (!I_RSTN)
                (control[g] & ~CTL_MASK) == 32'h0000_0000)
                else $error("reserved control bits not zero");

            // a software move to the counter replaces its value
            a_preload_wins: assert property (
                @(posedge I_REF_CLK) disable iff (!I_RSTN)
                (wr_hit && I_OPCODE_LOW == CNT_SEL)
                |=> count[g] == $past(I_WRITE_DATA))
                else $error("counter preload did not land");

            // a move to the control keeps only the defined fields
            a_control_write: assert property (
                @(posedge I_REF_CLK) disable iff (!I_RSTN)
                (wr_hit && I_OPCODE_LOW == CTL_SEL)
                |=> control[g] == ($past(I_WRITE_DATA) & CTL_MASK))
                else $error("control write kept wrong bits");

            // no qualifying mode means the count holds still
            a_mode_gates: assert property (
                @(posedge I_REF_CLK) disable iff (!I_RSTN)
                (!mode_ok[g] && !(wr_hit && I_OPCODE_LOW == CNT_SEL))
                |=> $stable(count[g]))
                else $error("counter moved with no mode enabled");
        end
    endgenerate

    //--------------------------------------------------------------
    // read path and interrupt
    //--------------------------------------------------------------
    // register read data, one cycle after the move
    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_READ_DATA  <= 32'h0000_0000;
            O_READ_VALID <= 1'b0;
        end else begin
            O_READ_VALID <= rd_hit;
            if (rd_hit) begin
                unique case (I_OPCODE_LOW)
                    SEL_CONTROL_0: O_READ_DATA <= control[0];
                    SEL_COUNTER_0: O_READ_DATA <= count[0];
                    SEL_CONTROL_1: O_READ_DATA <= control[1];
                    SEL_COUNTER_1: O_READ_DATA <= count[1];
                endcase
            end
        end
    end

    // overflow level held while msb set and enable set
    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_SHARED_INTERRUPT_LINE_SEVEN <= 1'b0;
        end else begin
            O_SHARED_INTERRUPT_LINE_SEVEN <=
                (count[0][COUNT_MSB] && control[0][CTL_IRQ_EN_BIT])
                || (count[1][COUNT_MSB] && control[1][CTL_IRQ_EN_BIT]);
        end
    end

    a_irq_needs_enable: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RSTN)
        (!control[0][CTL_IRQ_EN_BIT] && !control[1][CTL_IRQ_EN_BIT]) ##1
        (!control[0][CTL_IRQ_EN_BIT] && !control[1][CTL_IRQ_EN_BIT])
        |-> !O_SHARED_INTERRUPT_LINE_SEVEN)
        else $error("interrupt raised without enable");

    a_irq_on_overflow: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RSTN)
        (count[0][COUNT_MSB] && control[0][CTL_IRQ_EN_BIT])
        |=> O_SHARED_INTERRUPT_LINE_SEVEN)
        else $error("overflow did not raise interrupt");

    // counter 1 overflow with its enable also raises the line
    a_irq_counter_one: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RSTN)
        (count[1][COUNT_MSB] && control[1][CTL_IRQ_EN_BIT])
        |=> O_SHARED_INTERRUPT_LINE_SEVEN)
        else $error("counter 1 overflow did not raise interrupt");

    // with no enabled overflow left the line falls next cycle
    a_irq_released: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RSTN)
        !(count[0][COUNT_MSB] && control[0][CTL_IRQ_EN_BIT])
        && !(count[1][COUNT_MSB] && control[1][CTL_IRQ_EN_BIT])
        |=> !O_SHARED_INTERRUPT_LINE_SEVEN)
        else $error("interrupt held with no enabled overflow");

    a_cycle_event: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RSTN)
        (control[0][CTL_EVENT_MSB:CTL_EVENT_LSB] == 4'h0 && mode_ok[0]
         && !wr_hit) |=> count[0] == $past(count[0]) + 32'h0000_0001)
        else $error("cycle event did not count by one");

    a_read_back: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RSTN)
        (rd_hit && I_OPCODE_LOW == SEL_CONTROL_1 && !wr_hit)
        |=> O_READ_VALID && O_READ_DATA == control[1])
        else $error("control 1 read returned wrong data");

    a_branch_once: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RSTN)
        (control[0][CTL_EVENT_MSB:CTL_EVENT_LSB] == 4'h6 && mode_ok[0]
         && I_EVENTS.branch_resolved && !wr_hit)
        |=> count[0] == $past(count[0]) + 32'h0000_0001)
        else $error("branch event did not add exactly one");

    // graduated counts are added whole, not clipped to one
    a_grad_whole: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RSTN)
        (control[0][CTL_EVENT_MSB:CTL_EVENT_LSB] == 4'hF && mode_ok[0]
         && !wr_hit)
        |=> count[0] == $past(count[0])
            + {29'h0, $past(I_EVENTS.grad_count)})
        else $error("graduation count not added whole");

    // floating-point graduations on counter 1 are added whole
    a_fp_grad_whole: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RSTN)
        (control[1][CTL_EVENT_MSB:CTL_EVENT_LSB] == 4'h5 && mode_ok[1]
         && !wr_hit)
        |=> count[1] == $past(count[1])
            + {29'h0, $past(I_EVENTS.fp_grad_count)})
        else $error("fp graduation count not added whole");

    // a read of counter 0 returns the value held before the read edge
    a_read_counter: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RSTN)
        (rd_hit && I_OPCODE_LOW == SEL_COUNTER_0)
        |=> O_READ_VALID && O_READ_DATA == $past(count[0]))
        else $error("counter 0 read returned wrong data");

    // read valid is one pulse per read move and never spontaneous
    a_valid_pulse: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RSTN)
        !rd_hit |=> !O_READ_VALID)
        else $error("read valid without a read move");

endmodule : perf_event_counters

// ===== sim/event_source_model.sv
// far-side model: pipeline, cache and queue event sources
// assumes the bench requests one-cycle bursts on the processor clock
`timescale 1ns/10ps

module event_source_model
    import perf_event_pkg::*;
(
    input  wire logic    i_clk,
    input  wire logic    i_rstn,
    input  wire logic    i_fire,
    input  perf_events_s i_pattern,
    output perf_events_s o_events
);
    // burst lasts one cycle; lines fall quiet after it so nothing stray counts
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_events <= '0;
        end else begin
            o_events <= i_fire ? i_pattern : '0;
        end
    end
endmodule : event_source_model

// ===== sim/perf_event_counters_tb.sv
// self-checking bench for the performance event counters
// assumes the event source model and the package are compiled first
`timescale 1ns/10ps

module perf_event_counters_tb
    import perf_event_pkg::*;
;
    typedef struct packed {
        logic        c;
        logic [3:0]  ev;
        logic [3:0]  en;
        logic [3:0]  st;
        logic [31:0] inc;
    } row_s;

    logic         clk;
    logic         rstn;
    logic         mv_to;
    logic         mv_from;
    logic [4:0]   rsel;
    logic [1:0]   opc;
    logic [31:0]  wdata;
    logic         fire;
    perf_events_s pat;
    perf_events_s events;
    perf_status_s status;
    logic [31:0]  rd_data;
    logic         rd_valid;
    logic         irq;
    int           err_count;
    int           checks_done;
    row_s         rows[$];
    row_s         r;

    perf_event_counters uut (
        .I_REF_CLK(clk), .I_RSTN(rstn),
        .I_MOVE_TO_COPROCESSOR_ZERO(mv_to),
        .I_MOVE_FROM_COPROCESSOR_ZERO(mv_from), .I_REG_SELECTOR(rsel),
        .I_OPCODE_LOW(opc), .I_WRITE_DATA(wdata), .I_EVENTS(events),
        .I_STATUS(status), .O_READ_DATA(rd_data),
        .O_READ_VALID(rd_valid),
        .O_SHARED_INTERRUPT_LINE_SEVEN(irq));

    event_source_model src (.i_clk(clk), .i_rstn(rstn), .i_fire(fire),
        .i_pattern(pat), .o_events(events));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    // one write move, strobe held until the taking edge
    task automatic wr(input logic [4:0] s, input logic [1:0] o,
                      input logic [31:0] d);
        @(posedge clk);
        mv_to <= 1'b1;
        rsel  <= s;
        opc   <= o;
        wdata <= d;
        @(posedge clk);
        mv_to <= 1'b0;
    endtask : wr

    // one read move, answer checked in the cycle after the strobe
    task automatic rd(input logic [1:0] o, input logic [31:0] exp);
        @(posedge clk);
        mv_from <= 1'b1;
        rsel    <= PERF_REG_SELECTOR;
        opc     <= o;
        @(posedge clk);
        mv_from <= 1'b0;
        #1;
        chk("read_valid", {31'h0, rd_valid}, 32'h1);
        chk("read_data", rd_data, exp);
    endtask : rd

    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : ticks

    function automatic logic [31:0] exp_inc(input logic c,
                                            input logic [3:0] ev);
        logic [31:0] e;
        // event 0 sees three cycles, counts come whole, pulses add one
        e = 32'h0;
        case (ev)
            4'h0: e = 32'h3;
            4'h5: e = c ? 32'h4 : 32'h0;
            4'h6, 4'h7: e = 32'h1;
            4'h8, 4'h9: e = 32'h1;
            4'hA, 4'hB: e = 32'h1;
            4'hC, 4'hD: e = 32'h1;
            4'hE: e = 32'h1;
            4'hF: e = c ? 32'h1 : 32'h5;
            default: e = 32'h0;                     // unlisted events
        endcase
        return e;
    endfunction : exp_inc

    // ------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0; mv_to = 1'b0; mv_from = 1'b0; rsel = 5'h0;
        opc = 2'h0; wdata = 32'h0; fire = 1'b0; status = 4'h0;
        err_count = 0; checks_done = 0;
        pat = '1;
        pat.grad_count = 3'h5;
        pat.fp_grad_count = 3'h4;
        for (int i = 0; i < 32; i++) begin
            rows.push_back({i[4], i[3:0], 4'h4, 4'h0,
                            exp_inc(i[4], i[3:0])});
        end
        // mode qualification rows on counter 0, event 6
        rows.push_back({1'b0, 4'h6, 4'h1, 4'h8, 32'h1});
        rows.push_back({1'b0, 4'h6, 4'h2, 4'h4, 32'h1});
        rows.push_back({1'b0, 4'h6, 4'h8, 4'h2, 32'h1});
        rows.push_back({1'b0, 4'h6, 4'h4, 4'h8, 32'h0});
        rows.push_back({1'b0, 4'h6, 4'h4, 4'h2, 32'h0});
        rows.push_back({1'b0, 4'h6, 4'h8, 4'h3, 32'h0});
        rows.push_back({1'b0, 4'h6, 4'hF, 4'h1, 32'h0});
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        foreach (rows[i]) begin
            r = rows[i];
            @(posedge clk);
            status <= r.st;
            wr(PERF_REG_SELECTOR, {r.c, 1'b0}, {23'h0, r.ev, 1'b0, r.en});
            wr(PERF_REG_SELECTOR, {r.c, 1'b1}, 32'h0);
            @(posedge clk);
            fire <= 1'b1;
            @(posedge clk);
            fire <= 1'b0;
            rd({r.c, 1'b1}, r.inc);
        end
        $display("test event rows done");
        // reserved control bits and unmapped selector
        @(posedge clk);
        status <= 4'h0;
        wr(PERF_REG_SELECTOR, SEL_CONTROL_0, 32'hFFFF_FE00);
        rd(SEL_CONTROL_0, 32'h0000_0000);
        wr(PERF_REG_SELECTOR, SEL_CONTROL_1, 32'hFFFF_FFFF);
        rd(SEL_CONTROL_1, 32'h0000_01FF);
        wr(5'h18, SEL_CONTROL_1, 32'h0000_0000);
        rd(SEL_CONTROL_1, 32'h0000_01FF);
        $display("test register map done");
        // overflow interrupt, enabled and not
        wr(PERF_REG_SELECTOR, SEL_CONTROL_1, 32'h0000_0004);
        wr(PERF_REG_SELECTOR, SEL_COUNTER_1, 32'h7FFF_FFFF);
        wr(PERF_REG_SELECTOR, SEL_CONTROL_0, 32'h0000_0010);
        wr(PERF_REG_SELECTOR, SEL_COUNTER_0, 32'h7FFF_FFFF);
        ticks(3);
        chk("irq", {31'h0, irq}, 32'h0);
        rd(SEL_COUNTER_0, 32'h7FFF_FFFF);
        wr(PERF_REG_SELECTOR, SEL_CONTROL_0, 32'h0000_0014);
        ticks(3);
        chk("irq", {31'h0, irq}, 32'h1);
        ticks(4);
        chk("irq", {31'h0, irq}, 32'h1);
        // rewriting the counter below the msb drops the line
        wr(PERF_REG_SELECTOR, SEL_COUNTER_0, 32'h0000_0000);
        ticks(2);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(PERF_REG_SELECTOR, SEL_COUNTER_0, 32'h7FFF_FFFF);
        ticks(3);
        chk("irq", {31'h0, irq}, 32'h1);
        // clearing the enable drops the line
        wr(PERF_REG_SELECTOR, SEL_CONTROL_0, 32'h0000_0004);
        ticks(2);
        chk("irq", {31'h0, irq}, 32'h0);
        $display("test interrupt done");
        // second reset in mid-run
        @(posedge clk);
        rstn <= 1'b0;
        ticks(2);
        chk("irq", {31'h0, irq}, 32'h0);
        @(posedge clk);
        rstn <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            rd(k[1:0], 32'h0);
        end
        $display("test reset done");
        end_of_test();
    end
endmodule : perf_event_counters_tb
